// file: mode_reg_three_pkg.sv
// Constants, field layouts and encodings for the mode register three block
package mode_reg_three_pkg;
  // Clock and timing
  localparam int unsigned CLOCK_KHZ          = 200000;
  localparam int unsigned TEMP_STATUS_MAX_MS = 32;
  localparam int unsigned TEMP_STATUS_CYCLES = TEMP_STATUS_MAX_MS * CLOCK_KHZ;
  localparam int unsigned SYNC_STAGES        = 2;

  // Command pin, register word and store widths
  localparam int unsigned ADDR_W  = 18;
  localparam int unsigned MR_W    = 22;
  localparam int unsigned WORD_W  = 11;
  localparam int unsigned LOC_W   = 4;

  // Mode register select codes
  localparam logic [2:0] SEL_MR2 = 3'h2;
  localparam logic [2:0] SEL_MR3 = 3'h3;
  localparam logic [2:0] SEL_DNU = 3'h7;

  // Field positions inside a mode register word
  localparam int unsigned SEL_LSB      = 18;
  localparam int unsigned RSV_HI_BIT   = 21;
  localparam int unsigned RSV_MID_BIT  = 17;
  localparam int unsigned RSV_LO_BIT   = 13;
  localparam int unsigned FMT_LSB      = 11;
  localparam int unsigned WCL_LSB      = 9;
  localparam int unsigned FGR_LSB      = 6;
  localparam int unsigned TSS_BIT      = 5;
  localparam int unsigned PDA_BIT      = 4;
  localparam int unsigned GEAR_BIT     = 3;
  localparam int unsigned MPR_EN_BIT   = 2;
  localparam int unsigned PAGE_LSB     = 0;
  localparam int unsigned WTERM_LSB    = 9;
  localparam int unsigned WCRC_BIT     = 12;
  localparam int unsigned HALF_W       = 11;

  // Field encodings
  localparam logic [1:0] WCL_4CK   = 2'h0;
  localparam logic [1:0] WCL_5CK   = 2'h1;
  localparam logic [1:0] WCL_6CK   = 2'h2;
  localparam logic [3:0] LAT_4CK   = 4'h4;
  localparam logic [3:0] LAT_5CK   = 4'h5;
  localparam logic [3:0] LAT_6CK   = 4'h6;
  localparam logic [3:0] LAT_NONE  = 4'h0;
  localparam logic [3:0] UI_PLAIN  = 4'h8;
  localparam logic [3:0] UI_CRC    = 4'hA;
  localparam logic [2:0] WTERM_OFF = 3'h0;
  localparam logic [2:0] WTERM_MAX = 3'h4;
  localparam logic [1:0] FMT_RSV   = 2'h3;
  localparam logic [1:0] WCL_RSV   = 2'h3;

  // Multipurpose store pages
  localparam logic [1:0] PAGE_PATTERN = 2'h0;
  localparam logic [1:0] PAGE_MR_READ = 2'h1;
  localparam logic [1:0] PAGE_STATUS  = 2'h2;
  localparam logic [1:0] LOC_TEMP     = 2'h0;
  localparam int unsigned TEMP_LSB    = 3;

  // Command decode
  typedef enum logic [2:0] {CMD_NONE, CMD_MRS, CMD_READ, CMD_WRITE, CMD_OTHER} cmd_t;
  // Gear-down state
  typedef enum logic [1:0] {GEAR_HALF, GEAR_WAIT_SYNC, GEAR_QUARTER} gear_t;
endpackage : mode_reg_three_pkg

// file: multipurpose_store.sv
// Small register-read memory holding the multipurpose store pages
`timescale 1ns/10ps
module multipurpose_store #(
  parameter int unsigned DATA_W = 11,
  parameter int unsigned ADDR_W = 4
) (
  // Clock
  input  wire logic              clock,
  // Write port
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  // Read port
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [2**ADDR_W];

  initial begin
    if (DATA_W < 8 || ADDR_W < 4) $error("multipurpose_store: width or depth too small");
  end

  // Storage write
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read
  always_ff @(posedge clock) begin
    rdData <= mem[rdAddr];
  end
endmodule : multipurpose_store

// file: mode_reg_three_config.sv
// Mode register three decode, multipurpose store access and related features
// Function
// - Write termination applied during writes automatically
// - Write leveling uses nominal termination only
// - CRC extends write frame to ten UI
// - Register written by MRS, pin mapping
// - Bits 20:18 select target register
// - Bits 12:11 select store read format
// - Bits 10:9 set extra write latency
// - Bits 8:6 select refresh granularity
// - Bit 5 enables temperature status updates
// - Temperature status refreshed within 32 ms
// - Bit 4 enables per-device addressability
// - Bit 3 selects gear-down ratio
// - Bit 2 routes reads from store
// - Bits 1:0 select store page
// - Reads redirected to selected store location
// - Register readout split into two halves
// - Reset accepted during store access
// - Write termination field encoding
// - Quarter rate needs MRS then sync
`timescale 1ns/10ps
module mode_reg_three_config
  import mode_reg_three_pkg::*;
#(
  parameter int unsigned TEMP_UPDATE_CYCLES = mode_reg_three_pkg::TEMP_STATUS_CYCLES
) (
  // Clock and reset
  input  wire logic                               clock,
  input  wire logic                               nrst,
  // Command pins from the controller
  input  wire logic                               csN,
  input  wire logic                               actN,
  input  wire logic                               rasN,
  input  wire logic                               casN,
  input  wire logic                               weN,
  input  wire logic [1:0]                         bankGroup,
  input  wire logic [1:0]                         bankAddr,
  input  wire logic [mode_reg_three_pkg::ADDR_W-1:0] addr,
  input  wire logic                               syncPulse,
  // Device-internal status
  input  wire logic                               writeBurst,
  input  wire logic                               writeLevelMode,
  input  wire logic                               dataMaskEnable,
  input  wire logic [1:0]                         tempSensor,
  // Termination control
  output logic                                    termUseWrite,
  output logic [2:0]                              writeTermCode,
  // Write frame control
  output logic [3:0]                              frameUi,
  output logic [3:0]                              extraWriteLatency,
  // Mode outputs
  output logic [1:0]                              readFormat,
  output logic [2:0]                              refreshMode,
  output logic                                    tempStatusEnable,
  output logic                                    perDeviceEnable,
  output logic                                    gearQuarter,
  output logic                                    storeAccess,
  output logic [1:0]                              storePage,
  // Store read data
  output logic                                    readValid,
  output logic [mode_reg_three_pkg::WORD_W-1:0]   readData,
  // Error flags
  output logic                                    reservedSeen,
  output logic                                    storeCmdError
);
  import mode_reg_three_pkg::*;

  initial begin
    if (TEMP_UPDATE_CYCLES < 1 || TEMP_UPDATE_CYCLES > TEMP_STATUS_CYCLES)
      $error("mode_reg_three_config: temperature update period out of range");
  end

  localparam int unsigned CNT_W = $clog2(TEMP_STATUS_CYCLES + 1);

  // Two-stage synchronisers for the command pins and the temperature sensor
  localparam int unsigned PIN_W = 5 + 2 + 2 + ADDR_W + 1 + 2;
  logic [PIN_W-1:0] pinMeta_reg;
  logic [PIN_W-1:0] pinSync_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinMeta_reg <= '1;
      pinSync_reg <= '1;
    end else begin
      pinMeta_reg <= {csN, actN, rasN, casN, weN, bankGroup, bankAddr, addr, syncPulse, tempSensor};
      pinSync_reg <= pinMeta_reg;
    end
  end

  logic              sCsN;
  logic              sActN;
  logic              sRasN;
  logic              sCasN;
  logic              sWeN;
  logic [1:0]        sBg;
  logic [1:0]        sBa;
  logic [ADDR_W-1:0] sAddr;
  logic              sSync;
  logic [1:0]        sTemp;
  assign {sCsN, sActN, sRasN, sCasN, sWeN, sBg, sBa, sAddr, sSync, sTemp} = pinSync_reg;

  // Command decode from the synchronised pins
  cmd_t cmd;
  always_comb begin
    cmd = CMD_NONE;
    if (!sCsN && sActN) begin
      unique case ({sRasN, sCasN, sWeN})
        3'b000:  cmd = CMD_MRS;
        3'b101:  cmd = CMD_READ;
        3'b100:  cmd = CMD_WRITE;
        3'b111:  cmd = CMD_NONE;
        default: cmd = CMD_OTHER;
      endcase
    end else if (!sCsN) begin
      cmd = CMD_OTHER;
    end
  end

  // Full mode register word assembled from the pins
  logic [MR_W-1:0] mrsWord;
  assign mrsWord = {sBg, sBa, sAddr[17], 3'b000, sAddr[13:0]};
  logic [2:0] mrsSelect;
  assign mrsSelect = mrsWord[SEL_LSB +: 3];
  logic mrsToThree;
  logic mrsToTwo;
  assign mrsToThree = (cmd == CMD_MRS) && (mrsSelect == SEL_MR3);
  assign mrsToTwo   = (cmd == CMD_MRS) && (mrsSelect == SEL_MR2);

  // Mode register three contents
  logic [MR_W-1:0] modeThree_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      modeThree_reg <= '0;
    end else if (mrsToThree) begin
      modeThree_reg <= mrsWord;
    end
  end

  // Write termination and write CRC from mode register two
  logic [2:0] writeTerm_reg;
  logic       writeCrc_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      writeTerm_reg <= WTERM_OFF;
      writeCrc_reg  <= 1'b0;
    end else if (mrsToTwo) begin
      if (mrsWord[WTERM_LSB +: 3] <= WTERM_MAX) begin
        writeTerm_reg <= mrsWord[WTERM_LSB +: 3];
      end
      writeCrc_reg <= mrsWord[WCRC_BIT];
    end
  end

  // Reserved bit written as one, sticky until reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reservedSeen <= 1'b0;
    end else if (mrsToThree && (mrsWord[RSV_HI_BIT] || mrsWord[RSV_MID_BIT] || mrsWord[RSV_LO_BIT])) begin
      reservedSeen <= 1'b1;
    end else if (cmd == CMD_MRS && mrsSelect == SEL_DNU) begin
      reservedSeen <= 1'b1;
    end
  end

  // Decoded fields of register three
  logic [1:0] fmtField;
  logic [1:0] wclField;
  assign fmtField = modeThree_reg[FMT_LSB +: 2];
  assign wclField = modeThree_reg[WCL_LSB +: 2];

  // Mode outputs, reserved codes keep the prior setting
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      readFormat       <= '0;
      refreshMode      <= '0;
      tempStatusEnable <= 1'b0;
      perDeviceEnable  <= 1'b0;
      storeAccess      <= 1'b0;
      storePage        <= '0;
    end else begin
      if (fmtField != FMT_RSV) begin
        readFormat <= fmtField;
      end
      refreshMode      <= modeThree_reg[FGR_LSB +: 3];
      tempStatusEnable <= modeThree_reg[TSS_BIT];
      perDeviceEnable  <= modeThree_reg[PDA_BIT];
      storeAccess      <= modeThree_reg[MPR_EN_BIT];
      storePage        <= modeThree_reg[PAGE_LSB +: 2];
    end
  end

  // Extra write latency when both CRC and data mask are on
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      extraWriteLatency <= LAT_NONE;
    end else if (!(writeCrc_reg && dataMaskEnable)) begin
      extraWriteLatency <= LAT_NONE;
    end else begin
      unique case (wclField)
        WCL_4CK: extraWriteLatency <= LAT_4CK;
        WCL_5CK: extraWriteLatency <= LAT_5CK;
        WCL_6CK: extraWriteLatency <= LAT_6CK;
        WCL_RSV: extraWriteLatency <= extraWriteLatency;
      endcase
    end
  end

  // Write frame length
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frameUi <= UI_PLAIN;
    end else begin
      frameUi <= writeCrc_reg ? UI_CRC : UI_PLAIN;
    end
  end

  // Termination select during writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      termUseWrite  <= 1'b0;
      writeTermCode <= WTERM_OFF;
    end else begin
      writeTermCode <= writeTerm_reg;
      termUseWrite  <= writeBurst && !writeLevelMode && (writeTerm_reg != WTERM_OFF);
    end
  end

  // Gear-down: quarter rate only after the sync pulse
  gear_t gearState_reg;
  logic  syncSeen_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      syncSeen_reg <= 1'b1;                         // Matches the flop reset, no false edge
    end else begin
      syncSeen_reg <= sSync;
    end
  end
  logic syncRise;
  assign syncRise = sSync && !syncSeen_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gearState_reg <= GEAR_HALF;
    end else begin
      unique case (gearState_reg)
        GEAR_HALF: begin
          if (modeThree_reg[GEAR_BIT]) gearState_reg <= GEAR_WAIT_SYNC;
        end
        GEAR_WAIT_SYNC: begin
          if (!modeThree_reg[GEAR_BIT]) gearState_reg <= GEAR_HALF;
          else if (syncRise) gearState_reg <= GEAR_QUARTER;
        end
        GEAR_QUARTER: begin
          if (!modeThree_reg[GEAR_BIT]) gearState_reg <= GEAR_HALF;
        end
        default: gearState_reg <= GEAR_HALF;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gearQuarter <= 1'b0;
    end else begin
      gearQuarter <= (gearState_reg == GEAR_QUARTER);
    end
  end

  // Commands other than read, write or MRS to register three while store access is on
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      storeCmdError <= 1'b0;
    end else if (modeThree_reg[MPR_EN_BIT] && (cmd == CMD_OTHER || (cmd == CMD_MRS && !mrsToThree))) begin
      storeCmdError <= 1'b1;
    end
  end

  // Temperature status refresh timer
  logic [CNT_W-1:0] tempCnt_reg;
  logic             tempDue;
  assign tempDue = (tempCnt_reg == CNT_W'(TEMP_UPDATE_CYCLES - 1));
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tempCnt_reg <= '0;
    end else if (!modeThree_reg[TSS_BIT] || tempDue) begin
      tempCnt_reg <= '0;
    end else begin
      tempCnt_reg <= tempCnt_reg + 1'b1;
    end
  end

  // Pending temperature write, kept until the store port is free
  logic tempPending_reg;
  logic storeWrite;
  assign storeWrite = modeThree_reg[MPR_EN_BIT] && (cmd == CMD_WRITE);
  logic tempWrite;
  assign tempWrite = (tempPending_reg || tempDue) && !storeWrite && modeThree_reg[TSS_BIT];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tempPending_reg <= 1'b0;
    end else if (tempDue && storeWrite) begin
      tempPending_reg <= 1'b1;
    end else if (tempWrite || !modeThree_reg[TSS_BIT]) begin
      tempPending_reg <= 1'b0;
    end
  end

  // Store write port selection
  logic [LOC_W-1:0]  wrAddr;
  logic [WORD_W-1:0] wrData;
  always_comb begin
    wrAddr = {PAGE_STATUS, LOC_TEMP};
    wrData = '0;
    if (storeWrite) begin
      wrAddr = {PAGE_PATTERN, sBa};
      wrData = {3'b000, sAddr[7:0]};
    end else begin
      wrData[TEMP_LSB +: 2] = sTemp;
    end
  end

  // Store read, location from the read command's bank address
  logic              storeRead;
  logic [LOC_W-1:0]  rdAddr;
  logic [WORD_W-1:0] storeData;
  assign storeRead = modeThree_reg[MPR_EN_BIT] && (cmd == CMD_READ);
  assign rdAddr    = {modeThree_reg[PAGE_LSB +: 2], sBa};

  multipurpose_store #(
    .DATA_W (WORD_W),
    .ADDR_W (LOC_W)
  ) u_store (
    .clock  (clock),
    .wrEn   (storeWrite || tempWrite),
    .wrAddr (wrAddr),
    .wrData (wrData),
    .rdAddr (rdAddr),
    .rdData (storeData)
  );

  // Read pipeline aligned with the store latency
  logic       readStage_reg;
  logic [1:0] readLoc_reg;
  logic [1:0] readPage_reg;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      readStage_reg <= 1'b0;
      readLoc_reg   <= '0;
      readPage_reg  <= '0;
    end else begin
      readStage_reg <= storeRead;
      readLoc_reg   <= sBa;
      readPage_reg  <= modeThree_reg[PAGE_LSB +: 2];
    end
  end

  // Read data: register halves on the readout page, zero for the temperature location while status is off, store elsewhere
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      readValid <= 1'b0;
      readData  <= '0;
    end else begin
      readValid <= readStage_reg;
      if (readStage_reg) begin
        if (readPage_reg == PAGE_MR_READ) begin
          readData <= readLoc_reg[0] ? modeThree_reg[HALF_W +: HALF_W]
                                     : modeThree_reg[0 +: HALF_W];
        end else if (readPage_reg == PAGE_STATUS && readLoc_reg == LOC_TEMP && !modeThree_reg[TSS_BIT]) begin
          readData <= '0;
        end else begin
          readData <= storeData;
        end
      end
    end
  end
endmodule : mode_reg_three_config

// file: mode_reg_three_monitor.sv
// Checker for command decode timing of the mode register three block
`timescale 1ns/10ps
module mode_reg_three_monitor (
  // Clock, reset and pins
  input wire logic        clock, nrst, csN, actN, rasN, casN, weN, writeBurst, writeLevelMode,
  input wire logic [1:0]  bankGroup, bankAddr, readFormat, storePage,
  input wire logic [mode_reg_three_pkg::ADDR_W-1:0] addr,
  // Decoded outputs
  input wire logic        termUseWrite, tempStatusEnable, perDeviceEnable, storeAccess,
  input wire logic        readValid, reservedSeen, storeCmdError,
  input wire logic [2:0]  writeTermCode, refreshMode,
  input wire logic [3:0]  frameUi
);
  import mode_reg_three_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Commands as seen on the pins at the sampling edge
  wire logic       mrsCmd = !csN && actN && !rasN && !casN && !weN;
  wire logic       rdCmd  = !csN && actN && rasN && !casN && weN;
  wire logic       rsvBit = bankGroup[1] || addr[17] || addr[13];
  wire logic [2:0] sel    = {bankGroup[0], bankAddr};
  sequence mrs_to(s);
    mrsCmd && (sel == s);
  endsequence
  sequence mr3_clean;
    mrs_to(SEL_MR3) ##0 !rsvBit;
  endsequence

  chk_refresh_decode: assert property (mr3_clean |-> ##4 refreshMode == $past(addr[8:6], 4))
    else $error("refresh mode not taken from the command");
  chk_format_decode: assert property (mr3_clean ##0 (addr[12:11] != FMT_RSV) |-> ##4 readFormat == $past(addr[12:11], 4))
    else $error("read format not taken from the command");
  chk_store_fields: assert property (mr3_clean |-> ##4 {tempStatusEnable, perDeviceEnable, storeAccess, storePage} == $past({addr[5:4], addr[2:0]}, 4))
    else $error("status, addressing or store fields wrong");
  chk_crc_frame: assert property (mrs_to(SEL_MR2) |-> ##4 frameUi == ($past(addr[WCRC_BIT], 4) ? UI_CRC : UI_PLAIN))
    else $error("write frame length wrong");
  chk_term_code: assert property (mrs_to(SEL_MR2) ##0 (addr[11:9] <= WTERM_MAX) |-> ##4 writeTermCode == $past(addr[11:9], 4))
    else $error("write termination code wrong");
  chk_term_use: assert property ($past(nrst, 2) && $stable(writeTermCode) && $past(writeTermCode, 2) == writeTermCode |-> termUseWrite == $past(writeBurst && !writeLevelMode && writeTermCode != WTERM_OFF))
    else $error("termination choice wrong");
  chk_read_answer: assert property (readValid |-> $past(rdCmd, 4))
    else $error("read data without a read command");
  chk_reserved_bit: assert property (mrs_to(SEL_MR3) ##0 rsvBit |-> ##[3:5] reservedSeen)
    else $error("reserved bit write not flagged");
  chk_dnu_select: assert property (mrs_to(SEL_DNU) |-> ##[3:5] reservedSeen)
    else $error("do not use select not flagged");
  chk_store_error: assert property (storeAccess && !csN && !actN |-> ##[2:5] storeCmdError)
    else $error("forbidden command not flagged");
endmodule : mode_reg_three_monitor

bind mode_reg_three_config mode_reg_three_monitor mon (.clock, .nrst, .csN, .actN, .rasN, .casN, .weN,
  .writeBurst, .writeLevelMode, .bankGroup, .bankAddr, .readFormat, .storePage, .addr, .termUseWrite,
  .tempStatusEnable, .perDeviceEnable, .storeAccess, .readValid, .reservedSeen, .storeCmdError,
  .writeTermCode, .refreshMode, .frameUi);

// file: controller_model.sv
// Memory controller model issuing commands onto the command pins
`timescale 1ns/10ps
module controller_model (
  // Clock
  input  wire logic                                  clock,
  // Command pins
  output logic                                       csN, actN, rasN, casN, weN, syncPulse,
  output logic [1:0]                                 bankGroup, bankAddr,
  output logic [mode_reg_three_pkg::ADDR_W-1:0]      addr
);
  import mode_reg_three_pkg::*;
  // Deselected at time zero; a bank is opened only by the activate in task other
  initial begin
    {csN, actN, rasN, casN, weN, syncPulse} = 6'h3E;
    {bankGroup, bankAddr, addr} = '0;
  end
  // One command for one cycle, word bits placed on bank and address pins
  task automatic issue(input logic [2:0] rcw, input logic act, input logic [21:0] w);
    @(posedge clock);
    {csN, actN, rasN, casN, weN} <= {1'b0, act, rcw};
    {bankGroup, bankAddr} <= w[21:18];
    addr <= {w[17], 3'h0, w[13:0]};
  endtask : issue
  // Deselect; released lines show the inverse of their last value
  task automatic idle();
    @(posedge clock);
    {csN, actN, rasN, casN, weN} <= 5'h1F;
    {bankGroup, bankAddr, addr} <= ~{bankGroup, bankAddr, addr};
  endtask : idle
  // Mode register set, store enable included
  task automatic mrs(input logic [21:0] w);
    issue(3'h0, 1'b1, w);
    idle();
  endtask : mrs
  // Reads and writes, the only commands in store access besides MRS to register three
  task automatic rd(input logic [1:0] ba);
    issue(3'h5, 1'b1, {2'h0, ba, 18'h0});
  endtask : rd
  task automatic wr(input logic [1:0] ba, input logic [7:0] d);
    issue(3'h4, 1'b1, {2'h0, ba, 10'h0, d});
  endtask : wr
  // Activate, forbidden in store access, used on purpose
  task automatic other();
    issue(3'h7, 1'b0, 22'h0);
  endtask : other
  // Sync pulse after the gear-down write
  task automatic sync();
    @(posedge clock);
    syncPulse <= 1'b1;
    @(posedge clock);
    syncPulse <= 1'b0;
  endtask : sync
  // Latency code for a data rate in MT/s
  function automatic logic [1:0] wcl_for_rate(input int rate);
    if (rate <= 1600) return WCL_4CK;
    if (rate <= 2666) return WCL_5CK;
    return WCL_6CK;
  endfunction : wcl_for_rate
endmodule : controller_model

// file: tb_top.sv
// Self-checking testbench for the mode register three block
`timescale 1ns/10ps
module tb_top;
  import mode_reg_three_pkg::*;
  localparam int unsigned TEMP_CYC = 20;
  logic                clock = 1'b0;
  logic                nrst, writeBurst, writeLevelMode, dataMaskEnable, termUseWrite, tempStatusEnable;
  logic                csN, actN, rasN, casN, weN, syncPulse, perDeviceEnable, gearQuarter, storeAccess;
  logic                readValid, reservedSeen, storeCmdError;
  logic [1:0]          tempSensor, bankGroup, bankAddr, readFormat, storePage;
  logic [ADDR_W-1:0]   addr;
  logic [2:0]          writeTermCode, refreshMode;
  logic [3:0]          frameUi, extraWriteLatency;
  logic [WORD_W-1:0]   readData;
  logic [WORD_W-1:0]   expQ[$];
  int                  fails = 0;
  int                  comparisons = 0;

  mode_reg_three_config #(.TEMP_UPDATE_CYCLES(TEMP_CYC)) DUT (
    .clock, .nrst, .csN, .actN, .rasN, .casN, .weN, .bankGroup, .bankAddr, .addr, .syncPulse,
    .writeBurst, .writeLevelMode, .dataMaskEnable, .tempSensor, .termUseWrite, .writeTermCode,
    .frameUi, .extraWriteLatency, .readFormat, .refreshMode, .tempStatusEnable, .perDeviceEnable,
    .gearQuarter, .storeAccess, .storePage, .readValid, .readData, .reservedSeen, .storeCmdError);
  controller_model ctl (.clock, .csN, .actN, .rasN, .casN, .weN, .syncPulse, .bankGroup, .bankAddr, .addr);

  // Clock of 5 ns
  always #2.5 clock = ~clock;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_cyc
  task automatic end_of_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // Each read answer is compared with the oldest note
  always @(posedge clock) begin
    if (readValid === 1'b1) begin
      if (expQ.size() == 0) check(1'b1, 1'b0, "unexpected read answer");
      else check(readData, expQ.pop_front(), "read data");
    end
  end

  // Watchdog
  initial begin
    #100000;
    fails++;
    end_of_test();
  end

  // Main sequence
  initial begin
    logic [13:0] f;
    logic [21:0] w;
    logic [2:0]  e;
    logic [1:0]  t;
    logic [7:0]  d[4];
    static int   rates[3] = '{1600, 2400, 3200};
    {nrst, writeBurst, writeLevelMode, dataMaskEnable, tempSensor} = 6'h0;
    void'($urandom(32'h32AD5238));
    wait_cyc(4);
    nrst <= 1'b1;
    wait_cyc(2);
    check({frameUi, termUseWrite, writeTermCode, extraWriteLatency, readFormat, refreshMode}, {UI_PLAIN, 13'h0}, "reset");
    check({tempStatusEnable, perDeviceEnable, gearQuarter, storeAccess, storePage, reservedSeen, storeCmdError}, 8'h0, "reset flags");
    $display("test done: reset values");
    // Every refresh code with random status and addressing bits, then both halves read back from page one
    for (int i = 0; i < 8; i++) begin
      f = {1'b0, 2'(i % 3), 2'(i % 3), 3'(i), 2'($urandom()), 4'h5};
      w = {4'h3, 4'h0, f};
      ctl.mrs(w);
      wait_cyc(5);
      check(readFormat, f[12:11], "format");
      check(refreshMode, f[8:6], "refresh");
      check({tempStatusEnable, perDeviceEnable, storeAccess, storePage}, {f[5:4], 3'h5}, "fields");
      expQ.push_back(w[21:11]);
      expQ.push_back(w[10:0]);
      ctl.rd(2'h1);
      ctl.rd(2'h0);
      ctl.idle();
      wait_cyc(6);
    end
    $display("test done: field decode");
    // Latency matched to the rate, CRC frame, reserved codes refused
    ctl.mrs({4'h3, 18'h0}); // Store access off before other registers
    dataMaskEnable <= 1'b1;
    ctl.mrs({4'h2, 4'h0, 2'h1, 3'h1, 9'h0});
    foreach (rates[i]) begin
      ctl.mrs({4'h3, 4'h0, 3'h0, ctl.wcl_for_rate(rates[i]), 9'h0});
      wait_cyc(5);
      check(extraWriteLatency, 4'(4 + i), "write latency");
      check(frameUi, UI_CRC, "crc frame");
    end
    ctl.mrs({4'h3, 4'h0, 1'b0, FMT_RSV, WCL_RSV, 9'h0});
    wait_cyc(5);
    check({readFormat, extraWriteLatency}, {2'h0, LAT_6CK}, "reserved codes");
    dataMaskEnable <= 1'b0;
    wait_cyc(3);
    check(extraWriteLatency, LAT_NONE, "latency without mask");
    $display("test done: write latency");
    // Write termination for every code, then write leveling
    writeBurst <= 1'b1;
    e = WTERM_OFF;
    for (int i = 0; i < 8; i++) begin
      ctl.mrs({4'h2, 4'h0, 2'h0, 3'(i), 9'h0});
      if (3'(i) <= WTERM_MAX) e = 3'(i);
      wait_cyc(5);
      check({frameUi, writeTermCode}, {UI_PLAIN, e}, "term code");
      check(termUseWrite, e != WTERM_OFF, "term in write");
    end
    writeLevelMode <= 1'b1;
    wait_cyc(3);
    check(termUseWrite, 1'b0, "leveling");
    {writeBurst, writeLevelMode} <= 2'h0;
    $display("test done: termination");
    // Temperature status refreshed into page two, then disabled
    t = 2'($urandom());
    ctl.mrs({4'h3, 4'h0, 8'h0, 4'h9, PAGE_STATUS});
    for (int i = 0; i < 3; i++) begin
      tempSensor <= t;
      wait_cyc(TEMP_CYC + 6);
      if (i == 2) ctl.mrs({4'h3, 4'h0, 8'h0, 4'h1, PAGE_STATUS});
      expQ.push_back((i == 2) ? 11'h0 : 11'(t) << TEMP_LSB);
      ctl.rd(2'h0);
      ctl.idle();
      wait_cyc(6);
      t = ~t;
    end
    $display("test done: temperature");
    // Quarter rate only after the sync pulse
    ctl.mrs({4'h3, 4'h0, 10'h0, 4'h8});
    wait_cyc(10);
    check(gearQuarter, 1'b0, "gear before sync");
    ctl.sync();
    wait_cyc(6);
    check(gearQuarter, 1'b1, "gear after sync");
    ctl.mrs({4'h3, 18'h0});
    wait_cyc(5);
    check(gearQuarter, 1'b0, "gear back");
    check(reservedSeen, 1'b0, "no reserved yet");
    ctl.mrs({4'h7, 18'h5});
    wait_cyc(5);
    check({reservedSeen, storeAccess}, 2'h2, "select 111");
    $display("test done: gear and select");
    // Pattern writes and reads in page zero, forbidden command, reset in store access
    ctl.mrs({4'h3, 4'h0, 10'h0, 4'h4});
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($urandom());
      ctl.wr(2'(i), d[i]);
    end
    for (int i = 0; i < 4; i++) begin
      expQ.push_back({3'h0, d[i]});
      ctl.rd(2'(i));
    end
    check(storeCmdError, 1'b0, "no forbidden command yet");
    ctl.other();
    ctl.idle();
    wait_cyc(8);
    check(storeCmdError, 1'b1, "forbidden command");
    nrst <= 1'b0;
    wait_cyc(2);
    nrst <= 1'b1;
    wait_cyc(2);
    check({storeAccess, storeCmdError, reservedSeen, frameUi}, {3'h0, UI_PLAIN}, "reset in store");
    ctl.mrs({4'h3, 4'h0, 14'h2000});
    wait_cyc(5);
    check(reservedSeen, 1'b1, "reserved bit");
    check(expQ.size(), 0, "all reads answered");
    $display("test done: store access");
    end_of_test();
  end
endmodule : tb_top
